// ---- src/swv_pkg.sv ----
// shared constants and types of the write/verify command executor
package swv_pkg;
   localparam logic [7:0] OP_WRITE6 = 8'h0a;
   localparam logic [7:0] OP_WRITE10 = 8'h2a;
   localparam logic [7:0] OP_WRVFY = 8'h2e;
   localparam logic [7:0] OP_VERIFY = 8'h2f;
   // byte 1 and control byte bit positions, six-byte zero length value
   localparam int B1_RELATIVE_ADDRESSING_BIT = 0;
   localparam int B1_BYTE_COMPARE_SELECT = 1;
   localparam int B1_FUA = 3;
   localparam int B1_DPO = 4;
   localparam int CTL_LINK = 0;
   localparam int LBA6_MSB = 4;
   localparam logic [15:0] LEN6_ZERO = 16'h0100;
   // register byte addresses
   localparam logic [7:0] A_CDB0 = 8'h00;
   localparam logic [7:0] A_CDB1 = 8'h04;
   localparam logic [7:0] A_CDB2 = 8'h08;
   localparam logic [7:0] A_CTRL = 8'h0c;
   localparam logic [7:0] A_STAT = 8'h10;
   localparam logic [7:0] A_XFER = 8'h14;
   // control fields
   localparam int CTRL_GO = 0;
   localparam int CTRL_CACHE = 1;
   localparam int CTRL_RETN_LO = 4;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   // status fields
   localparam int ST_BUSY = 0;
   localparam int ST_DONE = 1;
   localparam int ST_SCSI_LO = 8;
   localparam int ST_KEY_LO = 16;
   localparam int ST_ASC_LO = 24;
   // scsi status, sense keys and additional sense codes
   localparam logic [7:0] SS_GOOD = 8'h00;
   localparam logic [7:0] SS_CHECK = 8'h02;
   localparam logic [7:0] SS_INTERM = 8'h10;
   localparam logic [3:0] SK_NONE = 4'h0;
   localparam logic [3:0] SK_MEDIUM = 4'h3;
   localparam logic [3:0] SK_ILLEGAL = 4'h5;
   localparam logic [3:0] SK_MISCMP = 4'he;
   localparam logic [7:0] ASC_NONE = 8'h00;
   localparam logic [7:0] ASC_WRERR = 8'h0c;
   localparam logic [7:0] ASC_UNREC = 8'h11;
   localparam logic [7:0] ASC_VFYCMP = 8'h1d;
   localparam logic [7:0] ASC_BADOP = 8'h20;
   localparam logic [7:0] ASC_BADFLD = 8'h24;
   localparam logic [3:0] RETN_LOWEST = 4'h0;
   typedef enum logic [2:0] {MOP_SEEK, MOP_WRITE, MOP_ECC, MOP_READ, MOP_FLUSH} swv_mop_e;
   typedef struct packed {
      swv_mop_e op;
      logic [31:0] lba;
      logic [15:0] cnt;
      logic force_media_write;
      logic [3:0] retn;
   } swv_mreq_s;
   typedef struct packed {
      logic [7:0] status;
      logic [3:0] key;
      logic [7:0] asc;
   } swv_sense_s;
endpackage

// ---- src/swv_core.sv ----
// write/verify command executor with apb register file and media interface
`timescale 1ns/1ps
module swv_core #(
   parameter int BLK_BYTES = 512
) (
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic DIN_VALID,
   input wire logic [7:0] DIN_DATA,
   output logic DIN_READY,
   output logic MED_REQ,
   output swv_pkg::swv_mreq_s MED_CMD,
   input wire logic MED_DONE,
   input wire logic MED_ERR,
   output logic MED_WR_VALID,
   output logic [7:0] MED_WR_DATA,
   input wire logic MED_RD_VALID,
   input wire logic [7:0] MED_RD_DATA,
   output logic MED_RD_READY
);
   import swv_pkg::*;

   typedef enum logic [3:0] {
      S_IDLE, S_DEC, S_FLUSH, S_FWAIT, S_WCMD, S_WDATA, S_WWAIT, S_VCMD, S_VDATA, S_VWAIT
   } swv_state_e;

   swv_state_e state_r;
   logic [31:0] cdb0_r, cdb1_r, cdb2_r, ctrl_r, xfer_r, rem_r;
   logic go_r, busy_r, done_r, fin_r, pready_r, pslverr_r;
   logic [31:0] prdata_r;
   swv_sense_s sense_r;
   logic [7:0] cdb [0:9];
   logic [7:0] hold_r;
   logic hold_v_r, byte_compare_select_r, is_wv_r, link_r, miscmp_r;
   logic mdone_r, merr_r;
   logic din_ready_r, med_req_r, wr_valid_r, rd_ready_r;
   logic [7:0] wr_data_r;
   swv_mreq_s mcmd_r;
   logic setup, access, wr_hit;

   assign cdb[0] = cdb0_r[7:0];
   assign cdb[1] = cdb0_r[15:8];
   assign cdb[2] = cdb0_r[23:16];
   assign cdb[3] = cdb0_r[31:24];
   assign cdb[4] = cdb1_r[7:0];
   assign cdb[5] = cdb1_r[15:8];
   assign cdb[6] = cdb1_r[23:16];
   assign cdb[7] = cdb1_r[31:24];
   assign cdb[8] = cdb2_r[7:0];
   assign cdb[9] = cdb2_r[15:8];

   function automatic logic is_ten(input logic [7:0] op);
      is_ten = (op == OP_WRITE10) || (op == OP_WRVFY) || (op == OP_VERIFY);
   endfunction

   function automatic logic [31:0] to_bytes(input logic [15:0] blocks);
      to_bytes = 32'(blocks) * 32'(BLK_BYTES);
   endfunction

   function automatic swv_sense_s mk(input logic [7:0] st, input logic [3:0] k, input logic [7:0] a);
      mk.status = st;
      mk.key = k;
      mk.asc = a;
   endfunction

   assign setup = PSEL && !PENABLE;
   assign access = PSEL && PENABLE && pready_r;
   assign wr_hit = access && PWRITE;

   // apb: no wait state, data and pready set during the setup cycle
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
      end else begin
         pready_r <= setup;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0000_0000;
         if (setup) begin
            unique case (PADDR)
               A_CDB0: prdata_r <= cdb0_r;
               A_CDB1: prdata_r <= cdb1_r;
               A_CDB2: prdata_r <= cdb2_r;
               A_CTRL: prdata_r <= ctrl_r;
               A_STAT: begin
                  prdata_r[ST_BUSY] <= busy_r;
                  prdata_r[ST_DONE] <= done_r;
                  prdata_r[ST_SCSI_LO +: 8] <= sense_r.status;
                  prdata_r[ST_KEY_LO +: 4] <= sense_r.key;
                  prdata_r[ST_ASC_LO +: 8] <= sense_r.asc;
               end
               A_XFER: prdata_r <= xfer_r;
               default: pslverr_r <= 1'b1;
            endcase
         end
      end
   end

   // descriptor and control registers; descriptor is frozen while busy
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         cdb0_r <= 32'h0000_0000;
         cdb1_r <= 32'h0000_0000;
         cdb2_r <= 32'h0000_0000;
         ctrl_r <= CTRL_RST;
         go_r <= 1'b0;
      end else begin
         go_r <= wr_hit && (PADDR == A_CTRL) && PWDATA[CTRL_GO] && !busy_r && !go_r;
         if (wr_hit && !busy_r) begin
            if (PADDR == A_CDB0) cdb0_r <= PWDATA;
            if (PADDR == A_CDB1) cdb1_r <= PWDATA;
            if (PADDR == A_CDB2) cdb2_r <= PWDATA;
         end
         if (wr_hit && PADDR == A_CTRL) begin
            ctrl_r <= PWDATA;
            ctrl_r[CTRL_GO] <= 1'b0;
         end
      end
   end

   // sticky completion flag: a finish in the clearing cycle wins
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         done_r <= 1'b0;
      end else begin
         done_r <= fin_r || (done_r && !(wr_hit && PADDR == A_STAT && PWDATA[ST_DONE]));
      end
   end

   // command sequencer
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_r <= S_IDLE;
         busy_r <= 1'b0;
         fin_r <= 1'b0;
         sense_r <= '0;
         mcmd_r <= '0;
         med_req_r <= 1'b0;
         rem_r <= 32'h0000_0000;
         xfer_r <= 32'h0000_0000;
         byte_compare_select_r <= 1'b0;
         is_wv_r <= 1'b0;
         link_r <= 1'b0;
         miscmp_r <= 1'b0;
         mdone_r <= 1'b0;
         merr_r <= 1'b0;
         din_ready_r <= 1'b0;
         rd_ready_r <= 1'b0;
         hold_v_r <= 1'b0;
         hold_r <= 8'h00;
         wr_valid_r <= 1'b0;
         wr_data_r <= 8'h00;
      end else begin
         fin_r <= 1'b0;
         med_req_r <= 1'b0;
         wr_valid_r <= 1'b0;
         unique case (state_r)
            S_IDLE: begin
               if (go_r) begin
                  busy_r <= 1'b1;
                  xfer_r <= 32'h0000_0000;
                  miscmp_r <= 1'b0;
                  state_r <= S_DEC;
               end
            end
            S_DEC: begin
               // only byte 1 flags and the link bit are looked at; reserved bits are ignored
               link_r <= is_ten(cdb[0]) ? cdb[9][CTL_LINK] : cdb[5][CTL_LINK];
               is_wv_r <= (cdb[0] == OP_WRVFY);
               byte_compare_select_r <= (cdb[0] == OP_WRVFY || cdb[0] == OP_VERIFY) && cdb[1][B1_BYTE_COMPARE_SELECT];
               mcmd_r.force_media_write <= (cdb[0] != OP_WRITE6) && cdb[1][B1_FUA]
                  || (cdb[0] == OP_WRVFY) && ctrl_r[CTRL_CACHE];
               mcmd_r.retn <= ((cdb[0] == OP_WRITE10 || cdb[0] == OP_WRVFY) && cdb[1][B1_DPO])
                  ? RETN_LOWEST : ctrl_r[CTRL_RETN_LO +: 4];
               if (cdb[0] == OP_WRITE6) begin
                  mcmd_r.lba <= {11'h000, cdb[1][LBA6_MSB:0], cdb[2], cdb[3]};
                  mcmd_r.cnt <= (cdb[4] == 8'h00) ? LEN6_ZERO : {8'h00, cdb[4]};
               end else begin
                  mcmd_r.lba <= {cdb[2], cdb[3], cdb[4], cdb[5]};
                  mcmd_r.cnt <= {cdb[7], cdb[8]};
               end
               if (!is_ten(cdb[0]) && cdb[0] != OP_WRITE6) begin
                  sense_r <= mk(SS_CHECK, SK_ILLEGAL, ASC_BADOP);
                  fin_r <= 1'b1;
                  busy_r <= 1'b0;
                  state_r <= S_IDLE;
               end else if (is_ten(cdb[0]) && cdb[1][B1_RELATIVE_ADDRESSING_BIT]) begin
                  sense_r <= mk(SS_CHECK, SK_ILLEGAL, ASC_BADFLD);
                  fin_r <= 1'b1;
                  busy_r <= 1'b0;
                  state_r <= S_IDLE;
               end else if ((cdb[0] == OP_VERIFY || cdb[0] == OP_WRVFY) && {cdb[7], cdb[8]} == 16'h0000) begin
                  sense_r <= mk(cdb[9][CTL_LINK] ? SS_INTERM : SS_GOOD, SK_NONE, ASC_NONE);
                  fin_r <= 1'b1;
                  busy_r <= 1'b0;
                  state_r <= S_IDLE;
               end else if (cdb[0] == OP_VERIFY) begin
                  state_r <= S_VCMD;
               end else if (cdb[0] == OP_WRVFY && ctrl_r[CTRL_CACHE]) begin
                  state_r <= S_FLUSH;
               end else begin
                  state_r <= S_WCMD;
               end
            end
            S_FLUSH: begin
               mcmd_r.op <= MOP_FLUSH;
               med_req_r <= 1'b1;
               state_r <= S_FWAIT;
            end
            S_FWAIT: begin
               if (MED_DONE) state_r <= S_WCMD;
            end
            S_WCMD: begin
               // zero blocks on the extended write still positions the heads
               mcmd_r.op <= (mcmd_r.cnt == 16'h0000) ? MOP_SEEK : MOP_WRITE;
               med_req_r <= 1'b1;
               rem_r <= to_bytes(mcmd_r.cnt);
               din_ready_r <= (mcmd_r.cnt != 16'h0000);
               state_r <= (mcmd_r.cnt == 16'h0000) ? S_WWAIT : S_WDATA;
            end
            S_WDATA: begin
               if (DIN_VALID && din_ready_r) begin
                  wr_valid_r <= 1'b1;
                  wr_data_r <= DIN_DATA;
                  xfer_r <= xfer_r + 32'h0000_0001;
                  rem_r <= rem_r - 32'h0000_0001;
                  if (rem_r == 32'h0000_0001) begin
                     din_ready_r <= 1'b0;
                     state_r <= S_WWAIT;
                  end
               end
            end
            S_WWAIT: begin
               // media raises done only once data is on the platter when fua is set
               if (MED_DONE) begin
                  if (MED_ERR) begin
                     sense_r <= mk(SS_CHECK, SK_MEDIUM, ASC_WRERR);
                     fin_r <= 1'b1;
                     busy_r <= 1'b0;
                     state_r <= S_IDLE;
                  end else if (is_wv_r) begin
                     state_r <= S_VCMD;
                  end else begin
                     sense_r <= mk(link_r ? SS_INTERM : SS_GOOD, SK_NONE, ASC_NONE);
                     fin_r <= 1'b1;
                     busy_r <= 1'b0;
                     state_r <= S_IDLE;
                  end
               end
            end
            S_VCMD: begin
               mcmd_r.op <= byte_compare_select_r ? MOP_READ : MOP_ECC;
               med_req_r <= 1'b1;
               rem_r <= to_bytes(mcmd_r.cnt);
               hold_v_r <= 1'b0;
               rd_ready_r <= byte_compare_select_r;
               mdone_r <= 1'b0;
               merr_r <= 1'b0;
               state_r <= byte_compare_select_r ? S_VDATA : S_VWAIT;
            end
            S_VDATA: begin
               // one disk byte is held and compared against one initiator byte
               // media ends its stream before the last initiator byte arrives, so its done is kept
               if (MED_DONE) begin
                  mdone_r <= 1'b1;
                  merr_r <= MED_ERR;
               end
               if (MED_RD_VALID && rd_ready_r) begin
                  hold_r <= MED_RD_DATA;
                  hold_v_r <= 1'b1;
                  rd_ready_r <= 1'b0;
                  din_ready_r <= 1'b1;
               end
               if (DIN_VALID && din_ready_r && hold_v_r) begin
                  din_ready_r <= 1'b0;
                  hold_v_r <= 1'b0;
                  xfer_r <= xfer_r + 32'h0000_0001;
                  rem_r <= rem_r - 32'h0000_0001;
                  if (DIN_DATA != hold_r) begin
                     miscmp_r <= 1'b1;
                     rd_ready_r <= 1'b1;
                     state_r <= S_VWAIT;
                  end else if (rem_r == 32'h0000_0001) begin
                     state_r <= S_VWAIT;
                  end else begin
                     rd_ready_r <= 1'b1;
                  end
               end
            end
            S_VWAIT: begin
               // after a miscompare the rest of the disk stream is drained and dropped
               if (MED_DONE || mdone_r) begin
                  rd_ready_r <= 1'b0;
                  fin_r <= 1'b1;
                  busy_r <= 1'b0;
                  state_r <= S_IDLE;
                  if (miscmp_r) begin
                     sense_r <= mk(SS_CHECK, SK_MISCMP, ASC_VFYCMP);
                  end else if ((MED_ERR || merr_r) && !byte_compare_select_r) begin
                     sense_r <= mk(SS_CHECK, SK_MEDIUM, ASC_UNREC);
                  end else if (MED_ERR || merr_r) begin
                     sense_r <= mk(SS_CHECK, SK_MEDIUM, ASC_UNREC);
                  end else begin
                     sense_r <= mk(link_r ? SS_INTERM : SS_GOOD, SK_NONE, ASC_NONE);
                  end
               end
            end
         endcase
      end
   end

   assign PRDATA = prdata_r;
   assign PREADY = pready_r;
   assign PSLVERR = pslverr_r;
   assign DIN_READY = din_ready_r;
   assign MED_REQ = med_req_r;
   assign MED_CMD = mcmd_r;
   assign MED_WR_VALID = wr_valid_r;
   assign MED_WR_DATA = wr_data_r;
   assign MED_RD_READY = rd_ready_r;
endmodule

// ---- sim/swv_core_props.sv ----
// concurrent checks on the executor's bus, initiator and media ports
`timescale 1ns/1ps
module swv_core_props import swv_pkg::*; (
   input wire logic REF_CLK,
   input wire logic RESETN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PREADY,
   input wire logic PSLVERR,
   input wire logic DIN_VALID,
   input wire logic [7:0] DIN_DATA,
   input wire logic DIN_READY,
   input wire logic MED_REQ,
   input wire swv_pkg::swv_mreq_s MED_CMD,
   input wire logic MED_DONE,
   input wire logic MED_WR_VALID,
   input wire logic [7:0] MED_WR_DATA,
   input wire logic MED_RD_READY
);
   logic act_r;
   // media op outstanding from request to done
   always_ff @(posedge REF_CLK or negedge RESETN) begin
      if (!RESETN)
         act_r <= 1'b0;
      else if (MED_REQ)
         act_r <= 1'b1;
      else if (MED_DONE)
         act_r <= 1'b0;
   end
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (!RESETN);
   property p_apb_ready; PSEL && !PENABLE |=> PREADY ##1 !PREADY; endproperty
   property p_apb_err; PSLVERR |-> PREADY && PSEL && PENABLE; endproperty
   property p_wr_fwd; DIN_VALID && DIN_READY && MED_CMD.op == MOP_WRITE |=> MED_WR_VALID && MED_WR_DATA == $past(DIN_DATA); endproperty
   property p_wr_cause; MED_WR_VALID |-> $past(DIN_VALID && DIN_READY); endproperty
   property p_ecc_quiet; MED_REQ && MED_CMD.op == MOP_ECC |-> (!DIN_READY && !MED_RD_READY) [*4]; endproperty
   property p_cmp_turn; act_r && MED_CMD.op == MOP_READ |-> !(DIN_READY && MED_RD_READY); endproperty
   property p_cmd_hold; act_r && !MED_REQ |-> $stable(MED_CMD); endproperty
   property p_req_one; MED_REQ |-> !act_r ##1 !MED_REQ; endproperty
   a_apb_ready: assert property (p_apb_ready) else $error("access not answered in one cycle");
   a_apb_err: assert property (p_apb_err) else $error("error flag outside an access");
   a_wr_fwd: assert property (p_wr_fwd) else $error("initiator byte not written");
   a_wr_cause: assert property (p_wr_cause) else $error("media byte without initiator byte");
   a_ecc_quiet: assert property (p_ecc_quiet) else $error("data moved in ecc check");
   a_cmp_turn: assert property (p_cmp_turn) else $error("both compare sides ready");
   a_cmd_hold: assert property (p_cmd_hold) else $error("media command changed mid op");
   a_req_one: assert property (p_req_one) else $error("media request overlaps");
   c_write: cover property (MED_REQ && MED_CMD.op == MOP_WRITE);
   c_read: cover property (MED_REQ && MED_CMD.op == MOP_READ);
   c_err: cover property (PSLVERR);
endmodule
bind swv_core swv_core_props u_props (.*);

// ---- sim/swv_media.sv ----
// media partner: seek, write, ecc check, read stream and flush
`timescale 1ns/1ps
module swv_media import swv_pkg::*; #(
   parameter int BLK = 4
) (
   input wire logic clk,
   input wire logic req,
   input wire swv_pkg::swv_mreq_s cmd,
   input wire logic wr_valid,
   input wire logic rd_ready,
   input wire logic [2:0] err_op,
   output logic done = 1'b0,
   output logic err = 1'b0,
   output logic rd_valid = 1'b0,
   output logic [7:0] rd_data
);
   int left_r = 0;
   int n;
   logic act_r = 1'b0;
   logic [7:0] idx_r = 8'h00;
   // idle line shows the inverse of the last byte, never a stale copy
   assign rd_data = rd_valid ? idx_r : ~(idx_r - 8'h01);
   always @(posedge clk) begin
      done <= 1'b0;
      err <= 1'b0;
      if (req) begin
         act_r <= 1'b1;
         idx_r <= cmd.lba[7:0];
         left_r <= cmd.op inside {MOP_WRITE, MOP_READ} ? int'(cmd.cnt) * BLK : 3;
      end else if (act_r) begin
         n = left_r - (cmd.op inside {MOP_WRITE, MOP_READ} ? int'(wr_valid) + int'(rd_valid && rd_ready) : 1);
         left_r <= n;
         if (rd_valid && rd_ready)
            idx_r <= idx_r + 8'h01;
         rd_valid <= cmd.op == MOP_READ && n > 0;
         if (n == 0) begin
            act_r <= 1'b0;
            done <= 1'b1;
            err <= 3'(cmd.op) == err_op;
         end
      end
   end
endmodule

// ---- sim/tb.sv ----
// self-checking bench for the write/verify executor
`timescale 1ns/1ps
module tb;
   import swv_pkg::*;
   localparam logic [31:0] OK = 32'h0000_0002;
   logic REF_CLK = 1'b0;
   logic RESETN = 1'b0;
   logic PSEL = 1'b0;
   logic PENABLE = 1'b0;
   logic PWRITE = 1'b0;
   logic chk = 1'b0;
   logic [7:0] PADDR = 8'h00;
   logic [31:0] PWDATA = 32'h0;
   logic DIN_VALID = 1'b0;
   logic [7:0] DIN_DATA = 8'h00;
   logic [31:0] PRDATA, rd, ctl, lfsr = 32'h356d;
   logic PREADY, PSLVERR, DIN_READY, MED_REQ, MED_DONE, MED_ERR, MED_WR_VALID, MED_RD_VALID, MED_RD_READY;
   logic [7:0] MED_WR_DATA, MED_RD_DATA;
   logic [2:0] err_op = 3'h7;
   swv_mreq_s MED_CMD;
   logic [63:0] sq[$], e;
   logic [111:0] mq[$], m;
   logic [7:0] dq[$];
   int mismatches = 0, cmp_count = 0, cyc = 0;
   swv_core #(.BLK_BYTES(4)) uut (.*);
   swv_media #(.BLK(4)) u_med (.clk(REF_CLK), .req(MED_REQ), .cmd(MED_CMD), .wr_valid(MED_WR_VALID),
      .rd_ready(MED_RD_READY), .err_op(err_op), .done(MED_DONE), .err(MED_ERR), .rd_valid(MED_RD_VALID),
      .rd_data(MED_RD_DATA));
   function automatic logic [31:0] lf(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function automatic logic [79:0] c10(input logic [7:0] op, b1, input logic [31:0] l, input logic [15:0] n);
      return {8'h00, n[7:0], n[15:8], 8'h00, l[7:0], l[15:8], l[23:16], l[31:24], b1, op};
   endfunction
   function automatic logic [31:0] sw(input logic [7:0] s, input logic [3:0] k, input logic [7:0] a);
      return {a, 4'h0, k, s, 8'h02};
   endfunction
   task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
      cmp_count = cmp_count + 1;
      if (got !== exp) begin
         mismatches = mismatches + 1;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic c);
      @(posedge REF_CLK);
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      chk <= c;
      @(posedge REF_CLK);
      PENABLE <= 1'b1;
      do @(posedge REF_CLK); while (PREADY !== 1'b1);
      rd = PRDATA;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
      chk <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] x);
      sq.push_back({mk, x});
      apb(1'b0, a, 32'h0, 1'b1);
   endtask
   task automatic mx(input swv_mop_e op, input logic [31:0] l, input logic f, input logic [3:0] r, input logic [55:0] mk);
      mq.push_back({mk, mk & {op, l, 16'h1, f, r}});
   endtask
   // base zero gives random bytes, otherwise the media's own pattern
   task automatic feed(input int n, input logic [7:0] base, input logic bad);
      for (int i = 0; i < n; i++)
         dq.push_back(base == 8'h00 ? lfsr[7:0] ^ 8'(i * 7) : (base + 8'(i)) ^ {8{bad && i == n - 1}});
   endtask
   task automatic run(input logic [79:0] c, input logic [31:0] st, input logic [31:0] nb);
      apb(1'b1, A_CDB0, c[31:0], 1'b0);
      apb(1'b1, A_CDB1, c[63:32], 1'b0);
      apb(1'b1, A_CDB2, {16'h0, c[79:64]}, 1'b0);
      apb(1'b1, A_CTRL, ctl | (32'h1 << CTRL_GO), 1'b0);
      do apb(1'b0, A_STAT, 32'h0, 1'b0); while (rd[ST_DONE] !== 1'b1);
      rchk(A_STAT, 32'hff0f_ff03, st);
      rchk(A_XFER, 32'hffff_ffff, nb);
      apb(1'b1, A_STAT, 32'h2, 1'b0);
   endtask
   always #5 REF_CLK = ~REF_CLK;
   always @(posedge REF_CLK) begin
      lfsr <= lf(lfsr);
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches = mismatches + 1;
         conclude();
      end
   end
   always @(posedge REF_CLK) if (!(DIN_VALID && !DIN_READY)) begin
      if (DIN_VALID)
         void'(dq.pop_front());
      DIN_VALID <= dq.size() != 0 && lfsr[1:0] != 2'h0;
      DIN_DATA <= dq.size() != 0 ? dq[0] : ~DIN_DATA;
   end
   always @(posedge REF_CLK) begin
      if (PSEL && PENABLE && PREADY && chk) begin
         e = sq.pop_front();
         cmp(64'(PRDATA & e[63:32]), 64'(e[31:0]));
         cmp(64'(PSLVERR), 64'(!(PADDR inside {A_CDB0, A_CDB1, A_CDB2, A_CTRL, A_STAT, A_XFER})));
      end
      if (MED_REQ) begin
         m = mq.size() != 0 ? mq.pop_front() : 112'h1;
         cmp(64'(MED_CMD & m[111:56]), 64'(m[55:0]));
      end
   end
   initial begin
      ctl = 32'h50;
      repeat (20) @(posedge REF_CLK);
      RESETN <= 1'b1;
      rchk(8'h40, 32'hffff_ffff, 32'h0);
      apb(1'b1, A_CTRL, ctl, 1'b0);
      rchk(A_CTRL, 32'hffff_ffff, ctl);
      mx(MOP_WRITE, 32'h001a_bcde, 1'b0, 4'h5, '1);
      feed(4, 8'h00, 1'b0);
      run({32'h0, 16'h0001, 8'hde, 8'hbc, 8'h1a, OP_WRITE6}, OK, 4);
      mq.push_back({56'hff_ffff_ffff_ffe0, 3'(MOP_WRITE), 32'h5, LEN6_ZERO, 5'h0});
      feed(1024, 8'h00, 1'b0);
      run({32'h0, 16'h0000, 8'h05, 16'h0, OP_WRITE6}, OK, 1024);
      // plain write, hint and force set for cold data, then a media write error; relative bit kept zero
      for (int i = 0; i < 3; i++) begin
         err_op = i == 2 ? 3'(MOP_WRITE) : 3'h7;
         mx(MOP_WRITE, 32'h1234_5670 + i, i == 1, i == 1 ? RETN_LOWEST : 4'h5, '1);
         feed(4, 8'h00, 1'b0);
         run(c10(OP_WRITE10, i == 1 ? 8'h18 : 8'h00, 32'h1234_5670 + i, 16'h1),
            i == 2 ? sw(SS_CHECK, SK_MEDIUM, ASC_WRERR) : OK, 4);
      end
      mq.push_back({56'hff_ffff_ffe0_0000, 3'(MOP_SEEK), 32'hab_cdef, 21'h0});
      run(c10(OP_WRITE10, 8'h00, 32'hab_cdef, 16'h0), OK, 0);
      for (int i = 0; i < 4; i++)
         run(c10(i == 3 ? 8'h3c : i == 0 ? OP_WRITE10 : i == 1 ? OP_WRVFY : OP_VERIFY, 8'h01, 32'h10, 16'h1),
            sw(SS_CHECK, SK_ILLEGAL, i == 3 ? ASC_BADOP : ASC_BADFLD), 0);
      for (int i = 0; i < 2; i++)
         run(c10(i ? OP_WRVFY : OP_VERIFY, 8'h02, 32'h20, 16'h0), OK, 0);
      for (int i = 0; i < 4; i++) begin
         err_op = i == 1 ? 3'(MOP_ECC) : 3'h7;
         mx(i > 1 ? MOP_READ : MOP_ECC, 32'h130, 1'b0, 4'h0, 56'hff_ffff_ffff_ffe0);
         feed(i > 1 ? 4 : 0, 8'h30, i == 3);
         run(c10(OP_VERIFY, i > 1 ? 8'h02 : 8'h00, 32'h130, 16'h1), i == 1 ? sw(SS_CHECK, SK_MEDIUM, ASC_UNREC) :
            i == 3 ? sw(SS_CHECK, SK_MISCMP, ASC_VFYCMP) : OK, i > 1 ? 4 : 0);
      end
      for (int i = 0; i < 4; i++) begin
         ctl = i < 2 ? 32'h52 : 32'h50;
         err_op = i == 1 ? 3'(MOP_ECC) : 3'h7;
         if (i < 2)
            mx(MOP_FLUSH, 32'h0, 1'b0, 4'h0, 56'he0_0000_0000_0000);
         mx(MOP_WRITE, 32'h240, i < 2, 4'h5, '1);
         mx(i < 2 ? MOP_ECC : MOP_READ, 32'h240, 1'b0, 4'h0, 56'hff_ffff_ffff_ffe0);
         feed(4, 8'h00, 1'b0);
         feed(i > 1 ? 4 : 0, 8'h40, i == 3);
         run(c10(OP_WRVFY, i < 2 ? 8'h00 : 8'h02, 32'h240, 16'h1) | (80'(i == 2) << 72),
            i == 1 ? sw(SS_CHECK, SK_MEDIUM, ASC_UNREC) : i == 3 ? sw(SS_CHECK, SK_MISCMP, ASC_VFYCMP) :
            i == 2 ? sw(SS_INTERM, SK_NONE, ASC_NONE) : OK, i > 1 ? 8 : 4);
      end
      RESETN <= 1'b0;
      repeat (3) @(posedge REF_CLK);
      RESETN <= 1'b1;
      rchk(A_CTRL, 32'hffff_ffff, CTRL_RST);
      conclude();
   end
endmodule
